// ---- rtl/fb_scaling_objects.sv ----
// per-feedback position, velocity and scaling object arrays
//
// How it works
// - every array answers subindex zero with the read-only entry count three.
// - each channel reports a signed 32-bit read-only actual position, preset zero.
// - each channel reports a signed 32-bit read-only actual velocity, preset zero.
// - subindex one is always the sensorless feedback, the rest follow sensor order.
// - each channel holds a signed 32-bit writable increment count, preset zero.
// - resolution per channel is increments divided by motor revolutions.
// - a zero increment count marks the channel unconnected; its sampling and switch-on check are skipped, its quotients are still computed.
// - at switch-on each non-zero channel is checked; failure sets an error and logs a code.
// - each channel holds a writable unsigned motor shaft revolutions value.
// - gear ratio per channel is motor shaft revolutions over driving shaft revolutions.
// - each channel holds an unsigned feed value for the feed constant.
// - increments go to the tuning save set; actual values are never saved.
// - feed constant per channel is feed over driving shaft revolutions.
`timescale 1ns/1ns
module fb_scaling_objects (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cycle_tick,
    input wire logic switch_on,
    input fb_scaling_pkg::fb_sample_t sample [3],
    input fb_scaling_pkg::obj_req_t req,
    output fb_scaling_pkg::obj_rsp_t rsp,
    output logic [2:0] channel_active,
    output logic status_error,
    output logic err_log_valid,
    output logic [15:0] err_log_code,
    output logic [31:0] resolution [3],
    output logic [31:0] gear_ratio [3],
    output logic [31:0] feed_constant [3],
    output logic [31:0] tuning_save_incr [3]
);
    typedef enum {CALC_IDLE, CALC_RES, CALC_GEAR, CALC_FEED} calc_state_t;

    logic [31:0] pos_reg [3];
    logic [31:0] vel_reg [3];
    logic [31:0] incr_reg [3];
    logic [31:0] motor_rev_reg [3];
    logic [31:0] gear_motor_reg [3];
    logic [31:0] gear_drive_reg [3];
    logic [31:0] feed_reg [3];
    logic [31:0] feed_drive_reg [3];
    logic [2:0] check_pend_reg;
    calc_state_t calc_reg;
    logic [1:0] calc_ch_reg;
    logic div_start, div_busy, div_done;
    logic [31:0] div_q, div_a, div_b;

    function automatic logic [1:0] ch_of(input logic [7:0] sub);
        return 2'(sub - fb_scaling_pkg::SUB_SENSORLESS);
    endfunction : ch_of

    // subindex one maps to array slot zero, the sensorless one
    wire sub_valid = req.subindex >= fb_scaling_pkg::SUB_SENSORLESS
        && req.subindex <= fb_scaling_pkg::ENTRY_COUNT;
    wire sub_count = req.subindex == fb_scaling_pkg::SUB_COUNT;
    wire [1:0] ch = ch_of(req.subindex);
    wire idx_pos = req.index == fb_scaling_pkg::IDX_POS_ACTUAL;
    wire idx_vel = req.index == fb_scaling_pkg::IDX_VEL_ACTUAL;
    wire idx_inc = req.index == fb_scaling_pkg::IDX_ENC_INCR;
    wire idx_mrv = req.index == fb_scaling_pkg::IDX_MOTOR_REV_RES;
    wire idx_gm = req.index == fb_scaling_pkg::IDX_GEAR_MOTOR;
    wire idx_gd = req.index == fb_scaling_pkg::IDX_GEAR_DRIVE;
    wire idx_fd = req.index == fb_scaling_pkg::IDX_FEED;
    wire idx_fdd = req.index == fb_scaling_pkg::IDX_FEED_DRIVE;
    wire idx_any = idx_pos | idx_vel | idx_inc | idx_mrv | idx_gm | idx_gd | idx_fd | idx_fdd;
    // count and actual values are not writable
    wire wr_ok = req.wr && sub_valid && !idx_pos && !idx_vel && idx_any;

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = fb_scaling_pkg::RESET_ZERO;
        if (sub_count)
            rd_val = {24'h000000, fb_scaling_pkg::ENTRY_COUNT};
        else if (idx_pos)
            rd_val = pos_reg[ch];
        else if (idx_vel)
            rd_val = vel_reg[ch];
        else if (idx_inc)
            rd_val = incr_reg[ch];
        else if (idx_mrv)
            rd_val = motor_rev_reg[ch];
        else if (idx_gm)
            rd_val = gear_motor_reg[ch];
        else if (idx_gd)
            rd_val = gear_drive_reg[ch];
        else if (idx_fd)
            rd_val = feed_reg[ch];
        else if (idx_fdd)
            rd_val = feed_drive_reg[ch];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            rsp <= '0;
        else
        begin
            rsp.valid <= req.rd | req.wr;
            rsp.ok <= idx_any && (sub_count || sub_valid) && (req.rd || wr_ok);
            rsp.rdata <= req.rd ? rd_val : fb_scaling_pkg::RESET_ZERO;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < fb_scaling_pkg::CH_COUNT; i++)
            begin
                pos_reg[i] <= fb_scaling_pkg::RESET_ZERO;
                vel_reg[i] <= fb_scaling_pkg::RESET_ZERO;
                incr_reg[i] <= fb_scaling_pkg::RESET_ZERO;
                motor_rev_reg[i] <= fb_scaling_pkg::RESET_ONE;
                gear_motor_reg[i] <= fb_scaling_pkg::RESET_ONE;
                gear_drive_reg[i] <= fb_scaling_pkg::RESET_ONE;
                feed_reg[i] <= fb_scaling_pkg::RESET_ONE;
                feed_drive_reg[i] <= fb_scaling_pkg::RESET_ONE;
            end
        end
        else
        begin
            for (int i = 0; i < fb_scaling_pkg::CH_COUNT; i++)
            begin
                // unconnected channels keep their last value, saving work
                if (cycle_tick && channel_active[i])
                begin
                    pos_reg[i] <= sample[i].position;
                    vel_reg[i] <= sample[i].velocity;
                end
            end
            if (wr_ok && idx_inc)
                incr_reg[ch] <= req.wdata;
            if (wr_ok && idx_mrv)
                motor_rev_reg[ch] <= req.wdata;
            if (wr_ok && idx_gm)
                gear_motor_reg[ch] <= req.wdata;
            if (wr_ok && idx_gd)
                gear_drive_reg[ch] <= req.wdata;
            if (wr_ok && idx_fd)
                feed_reg[ch] <= req.wdata;
            if (wr_ok && idx_fdd)
                feed_drive_reg[ch] <= req.wdata;
        end
    end

    always_comb
    begin
        for (int i = 0; i < fb_scaling_pkg::CH_COUNT; i++)
        begin
            channel_active[i] = incr_reg[i] != fb_scaling_pkg::RESET_ZERO;
            tuning_save_incr[i] = incr_reg[i];
        end
    end

    // switch-on check: all pending channels in the same cycle, error stays until reset
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            check_pend_reg <= '0;
            status_error <= 1'b0;
            err_log_valid <= 1'b0;
            err_log_code <= '0;
        end
        else
        begin
            err_log_valid <= 1'b0;
            if (switch_on)
                check_pend_reg <= channel_active;
            else
            begin
                for (int i = 0; i < fb_scaling_pkg::CH_COUNT; i++)
                begin
                    if (check_pend_reg[i])
                    begin
                        check_pend_reg[i] <= 1'b0;
                        if (!sample[i].signal_ok || !sample[i].config_ok)
                        begin
                            status_error <= 1'b1;
                            err_log_valid <= 1'b1;
                            err_log_code <= fb_scaling_pkg::ERR_CODE_FEEDBACK;
                        end
                    end
                end
            end
        end
    end

    // one shared divider walks channels and the three quotients in turn
    always_comb
    begin
        div_a = incr_reg[calc_ch_reg];
        div_b = motor_rev_reg[calc_ch_reg];
        if (calc_reg == CALC_GEAR)
        begin
            div_a = gear_motor_reg[calc_ch_reg];
            div_b = gear_drive_reg[calc_ch_reg];
        end
        else if (calc_reg == CALC_FEED)
        begin
            div_a = feed_reg[calc_ch_reg];
            div_b = feed_drive_reg[calc_ch_reg];
        end
    end
    assign div_start = calc_reg != CALC_IDLE && !div_busy && !div_done;

    ratio_divider u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(div_start),
        .dividend(div_a),
        .divisor(div_b),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            calc_reg <= CALC_IDLE;
            calc_ch_reg <= '0;
            for (int i = 0; i < fb_scaling_pkg::CH_COUNT; i++)
            begin
                resolution[i] <= '0;
                gear_ratio[i] <= '0;
                feed_constant[i] <= '0;
            end
        end
        else
        begin
            case (calc_reg)
                CALC_IDLE:
                    if (cycle_tick)
                        calc_reg <= CALC_RES;
                CALC_RES:
                    if (div_done)
                    begin
                        resolution[calc_ch_reg] <= div_q;
                        calc_reg <= CALC_GEAR;
                    end
                CALC_GEAR:
                    if (div_done)
                    begin
                        gear_ratio[calc_ch_reg] <= div_q;
                        calc_reg <= CALC_FEED;
                    end
                CALC_FEED:
                    if (div_done)
                    begin
                        feed_constant[calc_ch_reg] <= div_q;
                        calc_reg <= CALC_IDLE;
                        calc_ch_reg <= (calc_ch_reg == 2'(fb_scaling_pkg::CH_COUNT - 1))
                            ? 2'h0 : calc_ch_reg + 2'h1;
                    end
                default:
                    calc_reg <= CALC_IDLE;
            endcase
        end
    end
endmodule : fb_scaling_objects

// ---- rtl/fb_scaling_pkg.sv ----
// shared constants and types for the per-feedback scaling objects
package fb_scaling_pkg;
    localparam int CH_COUNT = 3;
    localparam logic [7:0] ENTRY_COUNT = 8'h03;
    localparam logic [15:0] IDX_POS_ACTUAL = 16'h60E4;
    localparam logic [15:0] IDX_VEL_ACTUAL = 16'h60E5;
    localparam logic [15:0] IDX_ENC_INCR = 16'h60E6;
    localparam logic [15:0] IDX_MOTOR_REV_RES = 16'h60EB;
    localparam logic [15:0] IDX_GEAR_MOTOR = 16'h60E8;
    localparam logic [15:0] IDX_GEAR_DRIVE = 16'h60ED;
    localparam logic [15:0] IDX_FEED = 16'h60E9;
    localparam logic [15:0] IDX_FEED_DRIVE = 16'h60EE;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_SENSORLESS = 8'h01;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    localparam logic [31:0] RESET_ONE = 32'h00000001;
    localparam logic [15:0] ERR_CODE_FEEDBACK = 16'h7305;
    localparam int DIV_BITS = 32;
    // per-channel measurement sample from the feedback front end
    typedef struct packed {
        logic [31:0] position;
        logic [31:0] velocity;
        logic signal_ok;
        logic config_ok;
    } fb_sample_t;
    // object access request from the fieldbus side
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } obj_req_t;
    typedef struct packed {
        logic valid;
        logic ok;
        logic [31:0] rdata;
    } obj_rsp_t;
endpackage : fb_scaling_pkg

// ---- rtl/ratio_divider.sv ----
// sequential restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
module ratio_divider (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [31:0] divisor,
    output logic busy,
    output logic done,
    output logic [31:0] quotient
);
    logic [31:0] quot_reg;
    logic [32:0] rem_reg;
    logic [31:0] dvs_reg;
    logic [5:0] cnt_reg;
    logic [32:0] trial;
    assign trial = {rem_reg[31:0], quot_reg[31]} - {1'b0, dvs_reg};
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            quot_reg <= '0;
            rem_reg <= '0;
            dvs_reg <= '0;
            cnt_reg <= '0;
            quotient <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                quot_reg <= dividend;
                rem_reg <= '0;
                dvs_reg <= divisor;
                cnt_reg <= 6'(fb_scaling_pkg::DIV_BITS);
            end
            else if (busy)
            begin
                if (trial[32])
                begin
                    rem_reg <= {rem_reg[31:0], quot_reg[31]};
                    quot_reg <= {quot_reg[30:0], 1'b0};
                end
                else
                begin
                    rem_reg <= trial;
                    quot_reg <= {quot_reg[30:0], 1'b1};
                end
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // divide by zero gives zero rather than all ones
                    quotient <= (dvs_reg == '0) ? '0 :
                        (trial[32] ? {quot_reg[30:0], 1'b0} : {quot_reg[30:0], 1'b1});
                end
            end
        end
    end
endmodule : ratio_divider

// ---- verif/fb_front_end_model.sv ----
// feedback front end stand-in: per-channel samples with injectable faults
`timescale 1ns/1ns
module fb_front_end_model (
    input wire logic [31:0] base,
    input wire logic [2:0] fault,
    input wire logic [2:0] cfg_fault,
    output fb_scaling_pkg::fb_sample_t sample [3]
);
    // slot 0 is the sensorless feedback, the rest follow sensor order
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            sample[i].position = base + 32'(i);
            sample[i].velocity = 32'h00000000 - (base + 32'(i));
            sample[i].signal_ok = ~fault[i];
            sample[i].config_ok = ~cfg_fault[i];
        end
    end
endmodule : fb_front_end_model

// ---- verif/fb_scaling_objects_assertions.sv ----
// concurrent checks on the per-feedback object block ports
`timescale 1ns/1ns
module fb_scaling_objects_assertions (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic switch_on,
    input fb_scaling_pkg::obj_req_t req,
    input fb_scaling_pkg::obj_rsp_t rsp,
    input wire logic [2:0] channel_active,
    input wire logic status_error,
    input wire logic err_log_valid,
    input wire logic [15:0] err_log_code,
    input wire logic [31:0] tuning_save_incr [3]
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic req_any = req.rd || req.wr;
    AST_RSP_ONE: assert property (req_any |=> rsp.valid)
        else $error("response missing after request");
    AST_NO_SPUR: assert property (!req_any |=> !rsp.valid)
        else $error("response without request");
    AST_COUNT: assert property (req.rd && req.subindex == 8'h00 |=> rsp.rdata == 32'h00000003)
        else $error("entry count not three");
    AST_RO_POS: assert property (req.wr && req.index == 16'h60E4 |=> !rsp.ok)
        else $error("position write accepted");
    AST_RO_VEL: assert property (req.wr && req.index == 16'h60E5 |=> !rsp.ok)
        else $error("velocity write accepted");
    AST_SUB_MAX: assert property (req_any && req.subindex > 8'h03 |=> !rsp.ok)
        else $error("subindex above three accepted");
    AST_ACTIVE: assert property (channel_active == {|tuning_save_incr[2],
        |tuning_save_incr[1], |tuning_save_incr[0]})
        else $error("active set differs from increments");
    AST_INCR_WR: assert property (req.wr && req.index == 16'h60E6 && req.subindex == 8'h01
        |=> tuning_save_incr[0] == $past(req.wdata))
        else $error("increment write lost");
    AST_ERR_CODE: assert property (err_log_valid |-> status_error
        && err_log_code == fb_scaling_pkg::ERR_CODE_FEEDBACK)
        else $error("error log without error bit or code");
    AST_ERR_HOLD: assert property (status_error |=> status_error)
        else $error("error bit dropped");
    AST_ERR_CAUSE: assert property ($rose(status_error) |-> $past(switch_on)
        || $past(switch_on, 2) || $past(switch_on, 3) || $past(switch_on, 4))
        else $error("error bit without switch-on");
    cover property (err_log_valid);
    cover property (req.wr && req.index == 16'h60E6);
    cover property (rsp.valid && !rsp.ok);
    cover property (req.wr && req.index == 16'h60E6 && req.subindex == 8'h01);
endmodule : fb_scaling_objects_assertions

// ---- verif/test_fb_scaling_objects.sv ----
// self-checking bench for the per-feedback scaling objects
`timescale 1ns/1ns
module test_fb_scaling_objects;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cycle_tick = 1'b0;
    logic switch_on = 1'b0;
    logic [31:0] base = 32'h00000000;
    logic [2:0] fault = 3'h0;
    logic [2:0] cfg_fault = 3'h0;
    fb_scaling_pkg::fb_sample_t sample [3];
    fb_scaling_pkg::obj_req_t req = '0;
    fb_scaling_pkg::obj_rsp_t rsp;
    logic [2:0] channel_active;
    logic status_error;
    logic err_log_valid;
    logic [15:0] err_log_code;
    logic [31:0] resolution [3];
    logic [31:0] gear_ratio [3];
    logic [31:0] feed_constant [3];
    logic [31:0] tuning_save_incr [3];
    logic ok_q;
    logic [31:0] rd_q;
    logic [15:0] ix_tab [5] = '{16'h60E4, 16'h60E5, 16'h60E6, 16'h60E8, 16'h60E9};
    logic [31:0] pre_tab [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int n_log = 0;
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end
    fb_front_end_model u_fe (.base(base), .fault(fault), .cfg_fault(cfg_fault),
        .sample(sample));
    fb_scaling_objects DUT (.clk_sys(clk_sys), .resetn(resetn), .cycle_tick(cycle_tick),
        .switch_on(switch_on), .sample(sample), .req(req), .rsp(rsp),
        .channel_active(channel_active), .status_error(status_error),
        .err_log_valid(err_log_valid), .err_log_code(err_log_code),
        .resolution(resolution), .gear_ratio(gear_ratio), .feed_constant(feed_constant),
        .tuning_save_incr(tuning_save_incr));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // generous ceiling: the sequence needs about 600 cycles
    always @(posedge clk_sys)
    begin
        n_cyc <= n_cyc + 1;
        if (err_log_valid === 1'b1)
            n_log <= n_log + 1;
        if (n_cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // request held for its taking edge; answer read one cycle later
    task acc(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] wd);
        @(negedge clk_sys);
        req = '{rd: ~w, wr: w, index: ix, subindex: sb, wdata: wd};
        @(negedge clk_sys);
        req.rd = 1'b0;
        req.wr = 1'b0;
        ok_q = rsp.ok;
        rd_q = rsp.rdata;
        chk("valid", {31'h0, rsp.valid}, 32'h1);
    endtask : acc
    task rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] exp);
        acc(1'b0, ix, sb, 32'h0);
        chk("read ok", {31'h0, ok_q}, 32'h1);
        chk("rdata", rd_q, exp);
    endtask : rd
    task wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] wd);
        acc(1'b1, ix, sb, wd);
        chk("write ok", {31'h0, ok_q}, 32'h1);
    endtask : wr
    task bad(input logic w, input logic [15:0] ix, input logic [7:0] sb);
        acc(w, ix, sb, 32'h5A5A5A5A);
        chk("refused", {31'h0, ok_q}, 32'h0);
    endtask : bad
    task tick;
        @(negedge clk_sys);
        cycle_tick = 1'b1;
        @(negedge clk_sys);
        cycle_tick = 1'b0;
        repeat (120) @(negedge clk_sys);
    endtask : tick
    task pulse_sw;
        @(negedge clk_sys);
        switch_on = 1'b1;
        @(negedge clk_sys);
        switch_on = 1'b0;
        repeat (5) @(negedge clk_sys);
    endtask : pulse_sw
    initial
    begin
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        foreach (ix_tab[i])
        begin
            rd(ix_tab[i], 8'h00, 32'h00000003);
            for (logic [7:0] s = 8'h01; s <= 8'h03; s++)
                rd(ix_tab[i], s, pre_tab[i]);
        end
        bad(1'b1, 16'h60E4, 8'h01);
        bad(1'b1, 16'h60E5, 8'h02);
        bad(1'b1, 16'h60E6, 8'h00);
        bad(1'b0, 16'h60E6, 8'h04);
        bad(1'b0, 16'h6000, 8'h01);
        wr(16'h60E6, 8'h02, 32'h00000064);
        wr(16'h60EB, 8'h02, 32'h00000004);
        wr(16'h60E8, 8'h02, 32'h0000000C);
        wr(16'h60ED, 8'h02, 32'h00000003);
        wr(16'h60E9, 8'h02, 32'h00000032);
        wr(16'h60EE, 8'h02, 32'h00000005);
        wr(16'h60E6, 8'h03, 32'hFFFFFF9C);
        rd(16'h60E6, 8'h03, 32'hFFFFFF9C);
        chk("active", {29'h0, channel_active}, 32'h00000006);
        chk("save set", tuning_save_incr[1], 32'h00000064);
        base = 32'h00001000;
        repeat (3) tick();
        rd(16'h60E4, 8'h01, 32'h00000000);
        rd(16'h60E4, 8'h02, 32'h00001001);
        rd(16'h60E5, 8'h02, 32'hFFFFEFFF);
        chk("resolution", resolution[1], 32'h00000019);
        chk("gear", gear_ratio[1], 32'h00000004);
        chk("feed", feed_constant[1], 32'h0000000A);
        base = 32'h00002000;
        tick();
        rd(16'h60E4, 8'h03, 32'h00002002);
        // faulty sensorless channel is off, so no error expected
        fault = 3'b001;
        pulse_sw();
        chk("no error", {31'h0, status_error}, 32'h0);
        fault = 3'b101;
        pulse_sw();
        chk("error bit", {31'h0, status_error}, 32'h1);
        chk("log count", 32'(n_log), 32'h1);
        chk("log code", {16'h0, err_log_code}, 32'h00007305);
        // second reset in mid-run: sticky error clears, presets come back
        @(negedge clk_sys);
        resetn = 1'b0;
        fault = 3'b000;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        chk("error cleared", {31'h0, status_error}, 32'h0);
        chk("active after reset", {29'h0, channel_active}, 32'h0);
        rd(16'h60E6, 8'h02, 32'h00000000);
        rd(16'h60EB, 8'h02, 32'h00000001);
        // sensorless channel switched on, then its configuration reported bad
        wr(16'h60E6, 8'h01, 32'h00000001);
        chk("sensorless active", {29'h0, channel_active}, 32'h00000001);
        cfg_fault = 3'b001;
        pulse_sw();
        chk("config error", {31'h0, status_error}, 32'h1);
        chk("log count again", 32'(n_log), 32'h2);
        chk("log code again", {16'h0, err_log_code}, 32'h00007305);
        give_verdict();
    end
endmodule : test_fb_scaling_objects
bind fb_scaling_objects fb_scaling_objects_assertions u_chk (.clk_sys(clk_sys),
    .resetn(resetn), .switch_on(switch_on), .req(req), .rsp(rsp),
    .channel_active(channel_active), .status_error(status_error),
    .err_log_valid(err_log_valid), .err_log_code(err_log_code),
    .tuning_save_incr(tuning_save_incr));
